// >>> rtl/chs_pkg.sv
/*
 * Package for the charge sequencer and status encoder: states, timing
 * constants and pattern figures. Assumes a single 20 MHz logic clock.
 */
// Contract
// - below trickle threshold at cycle start, command one tenth current
// - trickle lasting over half an hour ends charging, flags bad battery
// - above trickle threshold, enter full constant-current phase
// - entering constant-voltage phase starts a four hour safety timer
// - timer expiry ends charging, no current until a new cycle
// - after termination, below recharge threshold starts a new cycle
// - running timer is cleared when battery drops below recharge threshold
// - below-recharge condition counts only after persisting over 1.3 ms
// - bus lockout low-then-high restarts charge cycle and safety timer
// - input current limit enabled only while bus is good
// - status pin low from charge start through normal charging
// - constant-voltage and one tenth current releases the status pin
// - during input current limit, one tenth indication is ignored
// - temperature fault: 35 kHz, duty 6.25/93.75 percent, 1.5 Hz swap
// - bad battery: 35 kHz, duty 12.5/87.5 percent, 6.1 Hz swap
// - status output open drain, only pulls low or floats
// - temperature fault pauses charging, and timer in constant voltage
// - grounded thermistor input disables all temperature handling
package chs_pkg;
    localparam longint CLK_HZ          = 20_000_000;
    localparam longint CLK_NS          = 50;
    // half hour and four hours in seconds, 1.3 ms in microseconds
    localparam longint TRKL_LIMIT_S    = 1800;
    localparam longint SAFETY_S        = 14400;
    localparam longint RECHG_DEGL_US   = 1300;
    localparam longint TRKL_CYC        = TRKL_LIMIT_S * CLK_HZ;
    localparam longint SAFETY_CYC      = SAFETY_S * CLK_HZ;
    // more than 1.3 ms: one cycle past the rounded-up figure
    localparam int     RECHG_DEGL_CYC  = int'((RECHG_DEGL_US * 1000 + CLK_NS - 1) / CLK_NS) + 1;
    localparam longint CARRIER_HZ      = 35_000;
    localparam int     CARRIER_CYC     = int'(CLK_HZ / CARRIER_HZ);
    // duty in sixteenths of the carrier period
    localparam int     NTC_DUTY_LO_16  = 1;
    localparam int     BAD_DUTY_LO_16  = 2;
    localparam longint NTC_BLINK_MHZ   = 1500;
    localparam longint BAD_BLINK_MHZ   = 6100;
    // half blink periods so both halves are equal
    localparam int     NTC_HALF_CYC    = int'(CLK_HZ * 1000 / (2 * NTC_BLINK_MHZ));
    localparam int     BAD_HALF_CYC    = int'(CLK_HZ * 1000 / (2 * BAD_BLINK_MHZ));
    localparam int     TMR_W           = 40;
    localparam int     CNT_W           = 24;

    typedef enum logic [2:0] {
        CHS_IDLE   = 3'b000,
        CHS_TRKL   = 3'b001,
        CHS_CC     = 3'b011,
        CHS_CV     = 3'b010,
        CHS_DONE   = 3'b110,
        CHS_BADBAT = 3'b111
    } chs_state_t;
endpackage : chs_pkg

// >>> rtl/chs_charger_seq.sv
/*
 * Charge sequencer and open-drain status encoder.
 * Assumes comparator inputs are asynchronous to i_sys_clk and the pad
 * resolves o_charge_status_pin from the output enable (low when enabled).
 */
`timescale 1ns/1ps
`default_nettype none
module chs_charger_seq
    import chs_pkg::*;
#(
    parameter longint P_TRKL_CYC  = TRKL_CYC,
    parameter longint P_SAFE_CYC  = SAFETY_CYC
) (
    input  wire logic i_sys_clk,
    input  wire logic i_nrst,
    input  wire logic i_charge_enable,
    input  wire logic i_below_trickle_threshold,
    input  wire logic i_below_recharge_threshold,
    input  wire logic i_cv_mode,
    input  wire logic i_below_c10,
    input  wire logic i_bus_undervoltage_lockout_ok,
    input  wire logic i_bus_above_system_rail,
    input  wire logic i_thermistor_out_of_range,
    input  wire logic i_thermistor_input_grounded,
    input  wire logic i_charge_status_pin,
    output logic      o_charge_status_pin,
    output logic      o_charge_status_pin_oe,
    output logic      o_charge_on,
    output logic      o_trickle_current,
    output logic      o_input_limit_enable,
    output logic      o_ntc_fault,
    output logic      o_bad_battery
);
    // three-stage synchronisers; change counts when stages 2 and 3 agree
    localparam int NS = 8;
    logic [NS-1:0] raw, s1_ff, s2_ff, s3_ff, flt_ff;
    assign raw = {i_charge_enable, i_below_trickle_threshold, i_below_recharge_threshold,
                  i_cv_mode, i_below_c10, i_bus_undervoltage_lockout_ok,
                  i_thermistor_out_of_range & ~i_thermistor_input_grounded,
                  i_bus_above_system_rail};
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            flt_ff <= '0;
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int k = 0; k < NS; k++) begin
                if (s2_ff[k] == s3_ff[k]) flt_ff[k] <= s3_ff[k];
            end
        end
    end
    logic en, low_trkl, low_rchg, cv, c10, bus_undervoltage_lockout_ok, thermistor_input, bus_rail;
    assign {en, low_trkl, low_rchg, cv, c10, bus_undervoltage_lockout_ok, thermistor_input, bus_rail} = flt_ff;

    // limit on only while bus is over lockout and margin above rail
    logic bus_undervoltage_lockout_d_ff;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus_undervoltage_lockout_d_ff            <= 1'b0;
            o_input_limit_enable <= 1'b0;
        end else begin
            bus_undervoltage_lockout_d_ff            <= bus_undervoltage_lockout_ok;
            o_input_limit_enable <= bus_undervoltage_lockout_ok & bus_rail;
        end
    end
    logic restart;
    assign restart = bus_undervoltage_lockout_ok & ~bus_undervoltage_lockout_d_ff;

    // recharge deglitch
    logic [CNT_W-1:0] rchg_cnt_ff;
    logic             rchg_ok;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) rchg_cnt_ff <= '0;
        else if (!low_rchg) rchg_cnt_ff <= '0;
        else if (!rchg_ok) rchg_cnt_ff <= rchg_cnt_ff + 1'b1;
    end
    assign rchg_ok = (rchg_cnt_ff >= CNT_W'(RECHG_DEGL_CYC));

    chs_state_t state_ff;
    chs_state_t nxt_state;
    logic [TMR_W-1:0] trkl_tmr_ff, safe_tmr_ff;
    logic trkl_exp, safe_exp;
    assign trkl_exp = ({24'h000000, trkl_tmr_ff} >= 64'(P_TRKL_CYC));
    assign safe_exp = ({24'h000000, safe_tmr_ff} >= 64'(P_SAFE_CYC));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CHS_IDLE:   if (en) nxt_state = low_trkl ? CHS_TRKL : CHS_CC;
            CHS_TRKL: begin
                if (trkl_exp) nxt_state = CHS_BADBAT;
                else if (!low_trkl) nxt_state = CHS_CC;
            end
            CHS_CC:     if (cv) nxt_state = CHS_CV;
            CHS_CV:     if (safe_exp) nxt_state = CHS_DONE;
            CHS_DONE:   if (rchg_ok) nxt_state = CHS_IDLE;
            CHS_BADBAT: nxt_state = CHS_BADBAT;
            default:    nxt_state = CHS_IDLE;
        endcase
        if (restart || !en) nxt_state = CHS_IDLE;
    end
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) state_ff <= CHS_IDLE;
        else state_ff <= nxt_state;
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) trkl_tmr_ff <= '0;
        else if (state_ff != CHS_TRKL) trkl_tmr_ff <= '0;
        else if (!thermistor_input && !trkl_exp) trkl_tmr_ff <= trkl_tmr_ff + 1'b1;
    end
    // timer runs only in constant voltage, pauses on temperature fault
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) safe_tmr_ff <= '0;
        else if (restart || state_ff != CHS_CV || rchg_ok) safe_tmr_ff <= '0;
        else if (!thermistor_input && !safe_exp) safe_tmr_ff <= safe_tmr_ff + 1'b1;
    end

    logic charging;
    assign charging = (state_ff == CHS_TRKL) || (state_ff == CHS_CC) || (state_ff == CHS_CV);
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_charge_on       <= 1'b0;
            o_trickle_current <= 1'b0;
        end else begin
            o_charge_on       <= (nxt_state == CHS_TRKL || nxt_state == CHS_CC
                                  || nxt_state == CHS_CV) && !thermistor_input;
            o_trickle_current <= (nxt_state == CHS_TRKL);
        end
    end

    // carrier and blink dividers
    logic [CNT_W-1:0] car_ff, ntc_blk_ff, bad_blk_ff;
    logic             ntc_hi_ff, bad_hi_ff;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            car_ff     <= '0;
            ntc_blk_ff <= '0;
            bad_blk_ff <= '0;
            ntc_hi_ff  <= 1'b0;
            bad_hi_ff  <= 1'b0;
        end else begin
            car_ff <= (car_ff == CNT_W'(CARRIER_CYC - 1)) ? '0 : car_ff + 1'b1;
            if (ntc_blk_ff == CNT_W'(NTC_HALF_CYC - 1)) begin
                ntc_blk_ff <= '0;
                ntc_hi_ff  <= ~ntc_hi_ff;
            end else ntc_blk_ff <= ntc_blk_ff + 1'b1;
            if (bad_blk_ff == CNT_W'(BAD_HALF_CYC - 1)) begin
                bad_blk_ff <= '0;
                bad_hi_ff  <= ~bad_hi_ff;
            end else bad_blk_ff <= bad_blk_ff + 1'b1;
        end
    end
    function automatic logic pwm_low(input logic [CNT_W-1:0] c, input int lo16, input logic hi);
        int on16;
        on16 = hi ? 16 - lo16 : lo16;
        return (32'(c) * 16) < (on16 * CARRIER_CYC);
    endfunction : pwm_low

    // c10 disregarded under input current limit so weak input never reads done
    logic done_ind, pull;
    assign done_ind = (state_ff == CHS_CV) && c10 && !o_input_limit_enable;
    always_comb begin
        if (state_ff == CHS_BADBAT) pull = pwm_low(car_ff, BAD_DUTY_LO_16, bad_hi_ff);
        else if (thermistor_input && charging) pull = pwm_low(car_ff, NTC_DUTY_LO_16, ntc_hi_ff);
        else pull = charging && !done_ind;
    end
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) o_charge_status_pin_oe <= 1'b0;
        else o_charge_status_pin_oe <= pull;
    end
    assign o_charge_status_pin = 1'b0;
    assign o_ntc_fault   = thermistor_input && charging && state_ff != CHS_BADBAT;
    assign o_bad_battery = (state_ff == CHS_BADBAT);

    property p_trkl_cur;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_TRKL) |-> o_trickle_current;
    endproperty
    a_trkl_cur: assert property (p_trkl_cur) else $error("trickle not commanded");
    property p_bad;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_TRKL && trkl_exp && !restart && en) |=> (state_ff == CHS_BADBAT);
    endproperty
    a_bad: assert property (p_bad) else $error("no bad battery on timeout");
    property p_cc;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_TRKL && !low_trkl && !trkl_exp && !restart && en) |=> state_ff == CHS_CC;
    endproperty
    a_cc: assert property (p_cc) else $error("no constant current entry");
    property p_safe_start;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_CC && $rose(cv)) ##1 (state_ff == CHS_CV) |-> safe_tmr_ff == '0;
    endproperty
    a_safe_start: assert property (p_safe_start) else $error("timer not from zero");
    property p_done_off;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_DONE) |=> !o_charge_on;
    endproperty
    a_done_off: assert property (p_done_off) else $error("current after expiry");
    property p_degl;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        $rose(rchg_ok) |-> $past(low_rchg, 8);
    endproperty
    a_degl: assert property (p_degl) else $error("recharge not deglitched");
    property p_restart;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        restart |=> (state_ff == CHS_IDLE && safe_tmr_ff == '0);
    endproperty
    a_restart: assert property (p_restart) else $error("lockout cycle no restart");
    property p_c10;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_CV && o_input_limit_enable && !thermistor_input) |=> o_charge_status_pin_oe;
    endproperty
    a_c10: assert property (p_c10) else $error("released under limit");
    property p_prio;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_BADBAT) |-> !o_ntc_fault;
    endproperty
    a_prio: assert property (p_prio) else $error("fault priority wrong");

    // sequencing holds, timer clears and pattern dividers
    property p_bad_off;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_BADBAT) |=> !o_charge_on;
    endproperty
    a_bad_off: assert property (p_bad_off) else $error("current in bad battery");
    property p_cc_full;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_CC) |-> !o_trickle_current;
    endproperty
    a_cc_full: assert property (p_cc_full) else $error("trickle in constant current");
    property p_cv_entry;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_CC && cv && en && !restart) |=> (state_ff == CHS_CV);
    endproperty
    a_cv_entry: assert property (p_cv_entry) else $error("no constant voltage entry");
    property p_safe_exp;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_CV && safe_exp && en && !restart) |=> (state_ff == CHS_DONE);
    endproperty
    a_safe_exp: assert property (p_safe_exp) else $error("no stop on timer expiry");
    property p_rchg_go;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_DONE && rchg_ok && en && !restart) |=> (state_ff == CHS_IDLE);
    endproperty
    a_rchg_go: assert property (p_rchg_go) else $error("no recharge cycle");
    property p_rchg_clr;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_CV && rchg_ok) |=> (safe_tmr_ff == '0);
    endproperty
    a_rchg_clr: assert property (p_rchg_clr) else $error("timer not cleared");
    property p_lim_off;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (!bus_undervoltage_lockout_ok || !bus_rail) |=> !o_input_limit_enable;
    endproperty
    a_lim_off: assert property (p_lim_off) else $error("limit on with bad bus");
    property p_pull_chg;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (charging && !thermistor_input && !done_ind) |=> o_charge_status_pin_oe;
    endproperty
    a_pull_chg: assert property (p_pull_chg) else $error("pin not low while charging");
    property p_release;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (done_ind && !thermistor_input) |=> !o_charge_status_pin_oe;
    endproperty
    a_release: assert property (p_release) else $error("pin not released at done");
    property p_ntc_blink;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (ntc_blk_ff == CNT_W'(NTC_HALF_CYC - 1)) |=> (ntc_hi_ff != $past(ntc_hi_ff));
    endproperty
    a_ntc_blink: assert property (p_ntc_blink) else $error("slow blink not swapped");
    property p_bad_blink;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (bad_blk_ff == CNT_W'(BAD_HALF_CYC - 1)) |=> (bad_hi_ff != $past(bad_hi_ff));
    endproperty
    a_bad_blink: assert property (p_bad_blink) else $error("fast blink not swapped");
    property p_od;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        1'b1 |-> !o_charge_status_pin;
    endproperty
    a_od: assert property (p_od) else $error("status pin driven high");
    property p_ntc_pause;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        thermistor_input |=> !o_charge_on;
    endproperty
    a_ntc_pause: assert property (p_ntc_pause) else $error("current during temp fault");
    property p_ntc_tmr;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (state_ff == CHS_CV && thermistor_input && !restart && !rchg_ok) |=> $stable(safe_tmr_ff);
    endproperty
    a_ntc_tmr: assert property (p_ntc_tmr) else $error("timer ran during temp fault");
    property p_carrier;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (car_ff == CNT_W'(CARRIER_CYC - 1)) |=> (car_ff == '0);
    endproperty
    a_carrier: assert property (p_carrier) else $error("carrier period wrong");

    c_bad:  cover property (@(posedge i_sys_clk) state_ff == CHS_BADBAT);
    c_done: cover property (@(posedge i_sys_clk) state_ff == CHS_DONE);
    c_rchg: cover property (@(posedge i_sys_clk) state_ff == CHS_DONE ##1 state_ff == CHS_IDLE);
    c_ntc:  cover property (@(posedge i_sys_clk) o_ntc_fault && o_charge_status_pin_oe);
    c_pin:  cover property (@(posedge i_sys_clk) o_charge_status_pin_oe && !i_charge_status_pin);
endmodule : chs_charger_seq
`default_nettype wire

// >>> verification/chs_status_host.sv
/*
 * Host reading the open-drain status pin through a pull-up, measuring
 * low time and period of each carrier cycle.
 * Assumes one clock shared with the charger and pin sampled per edge.
 */
`timescale 1ns/1ps
`default_nettype none
module chs_status_host (
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_oe,
    output logic             o_pin,
    output logic [15:0]      o_low,
    output logic [15:0]      o_period,
    output logic [7:0]       o_nmeas
);
    logic [15:0] cnt_ff;
    logic [15:0] low_ff;
    logic        prev_ff;

    // pull-up: a released pin reads high
    assign o_pin = i_oe ? 1'b0 : 1'b1;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_ff   <= 16'h0;
            low_ff   <= 16'h0;
            prev_ff  <= 1'b1;
            o_low    <= 16'h0;
            o_period <= 16'h0;
            o_nmeas  <= 8'h0;
        end else begin
            prev_ff <= o_pin;
            if (prev_ff && !o_pin) begin
                // half duty only shows at a blink edge: reading dropped
                if ({low_ff, 1'b0} != {1'b0, cnt_ff}) begin
                    o_low    <= low_ff;
                    o_period <= cnt_ff;
                    o_nmeas  <= o_nmeas + 8'h1;
                end
                cnt_ff <= 16'h1;
                low_ff <= 16'h1;
            end else begin
                cnt_ff <= cnt_ff + 16'h1;
                low_ff <= low_ff + 16'(!o_pin);
            end
        end
    end
endmodule : chs_status_host
`default_nettype wire

// >>> verification/test_charger_sequencer_status.sv
/*
 * Testbench for the charge sequencer: phases, timers, restart and pin.
 * Assumes short timer parameters; blink halves outlast the run.
 */
`timescale 1ns/1ps
`default_nettype none
module test_charger_sequencer_status;
    import chs_pkg::*;
    localparam longint TRK = 200;
    localparam longint SAF = 300;
    logic clk, nrst, en, btrk, brch, cv, c10, ok, rail, tout, tgnd;
    logic pin, pin_d, oe, on, trk, lim, thermistor_input, bad;
    logic [15:0] low, per;
    logic [7:0]  nmeas;
    int n_mismatch, total_checks, cycles;

    chs_charger_seq #(.P_TRKL_CYC(TRK), .P_SAFE_CYC(SAF)) dut (
        .i_sys_clk(clk), .i_nrst(nrst), .i_charge_enable(en),
        .i_below_trickle_threshold(btrk), .i_below_recharge_threshold(brch),
        .i_cv_mode(cv), .i_below_c10(c10), .i_bus_undervoltage_lockout_ok(ok),
        .i_bus_above_system_rail(rail), .i_thermistor_out_of_range(tout),
        .i_thermistor_input_grounded(tgnd), .i_charge_status_pin(pin),
        .o_charge_status_pin(pin_d), .o_charge_status_pin_oe(oe), .o_charge_on(on),
        .o_trickle_current(trk), .o_input_limit_enable(lim), .o_ntc_fault(thermistor_input),
        .o_bad_battery(bad));
    chs_status_host host (.i_sys_clk(clk), .i_nrst(nrst), .i_oe(oe), .o_pin(pin),
        .o_low(low), .o_period(per), .o_nmeas(nmeas));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("mismatches=%0d checks=%0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // two fresh readings so the first, partial one is discarded
    task automatic duty(input int lo16);
        int lo, k;
        logic good;
        lo = CARRIER_CYC * lo16 / 16;
        k = nmeas + 2;
        for (int i = 0; i < 3000 && nmeas < k; i++) cyc(1);
        good = (low >= lo - 1 && low <= lo + 1) ||
               (low >= CARRIER_CYC - lo - 1 && low <= CARRIER_CYC - lo + 1);
        check(per, CARRIER_CYC);
        check(good, 1'b1);
    endtask : duty

    task automatic t_trickle_bad();
        en = 1'b1; btrk = 1'b1;
        cyc(8);
        check({on, trk, oe, lim}, 4'hF);
        cyc(int'(TRK) + 12);
        check({bad, on, trk}, 3'h4);
        tout = 1'b1;
        duty(BAD_DUTY_LO_16);
        tout = 1'b0;
    endtask : t_trickle_bad

    task automatic t_restart();
        btrk = 1'b0; ok = 1'b0;
        cyc(8);
        check(lim, 1'b0);
        ok = 1'b1;
        cyc(8);
        check({on, trk, bad, lim}, 4'h9);
    endtask : t_restart

    task automatic t_ntc();
        tout = 1'b1;
        cyc(8);
        check({on, thermistor_input}, 2'h1);
        duty(NTC_DUTY_LO_16);
        tgnd = 1'b1;
        cyc(8);
        check({on, thermistor_input}, 2'h2);
        tgnd = 1'b0; tout = 1'b0;
        cyc(8);
    endtask : t_ntc

    task automatic t_cv_done();
        cv = 1'b1; c10 = 1'b1;
        cyc(8);
        check(oe, 1'b1);
        rail = 1'b0;
        cyc(8);
        check({oe, lim, pin, pin_d}, 4'h2);
        cyc(int'(SAF) - 40);
        check(on, 1'b1);
        cyc(40);
        check(on, 1'b0);
        cv = 1'b0; c10 = 1'b0; rail = 1'b1;
    endtask : t_cv_done

    task automatic t_recharge();
        brch = 1'b1;
        cyc(100);
        brch = 1'b0;
        cyc(10);
        check(on, 1'b0);
        brch = 1'b1;
        cyc(RECHG_DEGL_CYC - 10);
        check(on, 1'b0);
        cyc(40);
        check(on, 1'b1);
    endtask : t_recharge

    initial begin
        {nrst, en, btrk, brch, cv, c10, tout, tgnd} = 8'h00;
        ok = 1'b1; rail = 1'b1;
        n_mismatch = 0; total_checks = 0; cycles = 0;
        cyc(10);
        check({on, trk, oe, bad}, 4'h0);
        nrst = 1'b1;
        t_trickle_bad();
        t_restart();
        t_ntc();
        t_cv_done();
        t_recharge();
        tally_and_finish();
    end
endmodule : test_charger_sequencer_status
`default_nettype wire
